// >>> inc/asp9_pkg.sv
// constants, types and register map for the 9-bit serial port
package asp9_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h4;
  localparam logic [3:0] OFS_BAUD = 4'h8;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam int BIT_MODE = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_MCE = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TB8 = 3;
  localparam int BIT_RB8 = 2;
  localparam int BIT_TI = 1;
  localparam int BIT_RI = 0;
  localparam int BIT_RUN = 11;
  localparam int BIT_IEN = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] CSEL_SYS = 3'h0;
  localparam logic [2:0] CSEL_DIV4 = 3'h1;
  localparam logic [2:0] CSEL_DIV12 = 3'h2;
  localparam logic [2:0] CSEL_DIV48 = 3'h3;
  localparam logic [2:0] CSEL_EXTOSC = 3'h4;
  localparam logic [2:0] CSEL_EXTIN = 3'h5;
  localparam logic [5:0] TERM_DIV4 = 6'h03;
  localparam logic [5:0] TERM_DIV12 = 6'h0b;
  localparam logic [5:0] TERM_DIV48 = 6'h2f;
  localparam logic [2:0] TERM_EXTOSC = 3'h7;
  localparam logic [7:0] TIMER_TOP = 8'hff;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} asp9_rx_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP, TX_END} asp9_tx_e;
  typedef enum logic [1:0] {REG_NONE, REG_CONTROL, REG_DATA, REG_BAUD} asp9_reg_e;
endpackage : asp9_pkg

// >>> inc/asp9_baud_if.sv
// baud tick link between timer, transmitter and receiver
`timescale 1ns/100ps
`default_nettype none
interface asp9_baud_if;
  logic txBaud;
  logic rxBaud;
  logic rxRealign;
  modport gen (output txBaud, output rxBaud, input rxRealign);
  modport tx (input txBaud);
endinterface : asp9_baud_if
`default_nettype wire

// >>> verilog/asp9_baud_gen.sv
// baud timer, hidden receive copy and divide-by-two ticks
`timescale 1ns/100ps
`default_nettype none
module asp9_baud_gen (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic timerRun, // timer enable
  input wire logic [2:0] clkSel, // timer clock source
  input wire logic [7:0] reload, // reload byte
  input wire logic extOscClk, // external oscillator pin
  input wire logic extTimerIn, // external timer input pin
  asp9_baud_if.gen link // baud ticks out
);
  logic [1:0] pinIn;
  logic [1:0] rise;
  logic [5:0] preCnt;
  logic [5:0] preTerm;
  logic [2:0] oscCnt;
  logic timerTick;
  logic [7:0] txLow;
  logic [7:0] rxLow;
  logic txOvf;
  logic rxOvf;
  logic txHalf;
  logic rxHalf;
  assign pinIn = {extTimerIn, extOscClk};
  // three-stage pin filters, change counts once stages two and three agree
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic [2:0] sh;
    logic lvl;
    logic edgeP;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        sh <= 3'h0;
        lvl <= 1'b0;
        edgeP <= 1'b0;
      end else begin
        sh <= {sh[1:0], pinIn[i]};
        if (sh[1] == sh[2]) lvl <= sh[2];
        edgeP <= (sh[1] == sh[2]) && sh[2] && !lvl;
      end
    end
    assign rise[i] = edgeP;
  end
  always_comb begin
    case (clkSel)
      asp9_pkg::CSEL_DIV4: preTerm = asp9_pkg::TERM_DIV4;
      asp9_pkg::CSEL_DIV12: preTerm = asp9_pkg::TERM_DIV12;
      default: preTerm = asp9_pkg::TERM_DIV48;
    endcase
  end
  // one prescaler serves all three divided rates
  always_ff @(posedge clk) begin
    if (sys_rst || preCnt == preTerm) preCnt <= 6'h00;
    else preCnt <= preCnt + 6'h01;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) oscCnt <= 3'h0;
    else if (rise[0]) oscCnt <= oscCnt + 3'h1;
  end
  always_comb begin
    case (clkSel)
      asp9_pkg::CSEL_SYS: timerTick = 1'b1;
      asp9_pkg::CSEL_DIV4, asp9_pkg::CSEL_DIV12,
      asp9_pkg::CSEL_DIV48: timerTick = (preCnt == preTerm);
      asp9_pkg::CSEL_EXTOSC: timerTick = rise[0] && oscCnt == asp9_pkg::TERM_EXTOSC;
      asp9_pkg::CSEL_EXTIN: timerTick = rise[1];
      default: timerTick = 1'b0;
    endcase
  end
  assign txOvf = timerRun && timerTick && txLow == asp9_pkg::TIMER_TOP;
  assign rxOvf = timerRun && timerTick && rxLow == asp9_pkg::TIMER_TOP;
  always_ff @(posedge clk) begin
    if (sys_rst) txLow <= 8'h00;
    else if (txOvf) txLow <= reload;
    else if (timerRun && timerTick) txLow <= txLow + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) rxLow <= 8'h00;
    else if (link.rxRealign || rxOvf) rxLow <= reload;
    else if (timerRun && timerTick) rxLow <= rxLow + 8'h01;
  end
  // divide by two; rx phase preset so ticks fall at bit centres
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txHalf <= 1'b0;
      rxHalf <= 1'b0;
      link.txBaud <= 1'b0;
      link.rxBaud <= 1'b0;
    end else begin
      if (txOvf) txHalf <= !txHalf;
      link.txBaud <= txOvf && txHalf;
      if (link.rxRealign) rxHalf <= 1'b1;
      else if (rxOvf) rxHalf <= !rxHalf;
      link.rxBaud <= rxOvf && rxHalf && !link.rxRealign;
    end
  end
endmodule : asp9_baud_gen
`default_nettype wire

// >>> verilog/asp9_tx.sv
// frame transmitter paced by the transmit baud tick
`timescale 1ns/100ps
`default_nettype none
module asp9_tx (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic load, // start pulse
  input wire logic [7:0] data, // byte to send
  input wire logic ninth, // ninth bit value
  input wire logic nineBit, // 9-bit frame mode
  asp9_baud_if.tx link, // transmit tick
  output logic serialOut, // line, idles high
  output logic doneSet, // pulse at stop-bit start
  output logic busy // frame in progress
);
  asp9_pkg::asp9_tx_e state;
  logic [8:0] shift;
  logic [2:0] bitCnt;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= asp9_pkg::TX_IDLE;
      shift <= 9'h000;
      bitCnt <= 3'h0;
      serialOut <= 1'b1;
      doneSet <= 1'b0;
      busy <= 1'b0;
    end else begin
      doneSet <= 1'b0;
      case (state)
        asp9_pkg::TX_IDLE: if (load) begin
          shift <= {ninth, data};
          busy <= 1'b1;
          state <= asp9_pkg::TX_START;
        end
        asp9_pkg::TX_START: if (link.txBaud) begin
          serialOut <= 1'b0;
          bitCnt <= 3'h0;
          state <= asp9_pkg::TX_DATA;
        end
        asp9_pkg::TX_DATA: if (link.txBaud) begin
          serialOut <= shift[0];
          shift <= {1'b0, shift[8:1]};
          bitCnt <= bitCnt + 3'h1;
          if (bitCnt == asp9_pkg::LAST_DATA_BIT)
            state <= nineBit ? asp9_pkg::TX_NINTH : asp9_pkg::TX_STOP;
        end
        asp9_pkg::TX_NINTH: if (link.txBaud) begin
          serialOut <= shift[0];
          state <= asp9_pkg::TX_STOP;
        end
        // done at start of stop bit
        asp9_pkg::TX_STOP: if (link.txBaud) begin
          serialOut <= 1'b1;
          doneSet <= 1'b1;
          state <= asp9_pkg::TX_END;
        end
        default: if (link.txBaud) begin
          busy <= 1'b0;
          state <= asp9_pkg::TX_IDLE;
        end
      endcase
    end
  end
endmodule : asp9_tx
`default_nettype wire

// >>> verilog/asp9_top.sv
// serial port top: bus slave, control flags, receiver
`timescale 1ns/100ps
`default_nettype none
module asp9_top (
  input wire logic clk, // 20 MHz system clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic [asp9_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [asp9_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic serialInPin, // receive line
  output logic serialOutPin, // transmit line
  input wire logic extOscClk, // external oscillator
  input wire logic extTimerIn, // external timer input
  output logic irqReq // port interrupt request
);

  // control register fields
  logic frameNine;
  logic mceOn;
  logic renOn;
  logic tb8;
  logic rb8;
  logic txDoneFlag;
  logic rxDoneFlag;

  // baud configuration and receive buffer
  logic [7:0] reloadByte;
  logic [2:0] clkSel;
  logic timerRun;
  logic intEnable;
  logic [7:0] rxBuffer;

  // latched write channel
  logic [asp9_pkg::ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic wrDo;
  asp9_pkg::asp9_reg_e wrReg;
  asp9_pkg::asp9_reg_e rdReg;
  logic ctlWr;
  logic baudWr0;
  logic baudWr1;
  logic txLoad;
  logic [7:0] ctlVal;
  logic [31:0] rdVal;

  // transmitter side
  logic txDoneSet;
  logic txBusy;

  // receiver side
  asp9_pkg::asp9_rx_e rxState;
  logic [2:0] rxSh;
  logic rxLevel;
  logic rxStartEdge;
  logic [7:0] rxShift;
  logic [2:0] rxCnt;
  logic rxDone;
  logic rxCheckBit;
  logic rxNinthBit;
  logic rxAccept;

  asp9_baud_if baudLink ();

  // shared address decode for both channels
  function automatic asp9_pkg::asp9_reg_e decodeReg(
    input logic [asp9_pkg::ADDR_W-1:0] a
  );
    if (a == asp9_pkg::OFS_CONTROL) return asp9_pkg::REG_CONTROL;
    else if (a == asp9_pkg::OFS_DATA) return asp9_pkg::REG_DATA;
    else if (a == asp9_pkg::OFS_BAUD) return asp9_pkg::REG_BAUD;
    else return asp9_pkg::REG_NONE;
  endfunction : decodeReg

  asp9_baud_gen u_baud (
    .clk(clk),
    .sys_rst(sys_rst),
    .timerRun(timerRun),
    .clkSel(clkSel),
    .reload(reloadByte),
    .extOscClk(extOscClk),
    .extTimerIn(extTimerIn),
    .link(baudLink.gen)
  );

  asp9_tx u_tx (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(txLoad),
    .data(wDataQ[7:0]),
    .ninth(tb8),
    .nineBit(frameNine),
    .link(baudLink.tx),
    .serialOut(serialOutPin),
    .doneSet(txDoneSet),
    .busy(txBusy)
  );

  // write address channel, held until the response is taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awready <= 1'b1;
      awAddrQ <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awAddrQ <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  // write data channel, accepted in either order with the address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wready <= 1'b1;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // write commits once both halves are held
  assign wrDo = !awready && !wready && !bvalid;
  assign wrReg = decodeReg(awAddrQ);
  assign ctlWr = wrDo && wrReg == asp9_pkg::REG_CONTROL && wStrbQ[0];
  assign baudWr0 = wrDo && wrReg == asp9_pkg::REG_BAUD && wStrbQ[0];
  assign baudWr1 = wrDo && wrReg == asp9_pkg::REG_BAUD && wStrbQ[1];
  // writes go to transmitter; busy writes are dropped
  assign txLoad = wrDo && wrReg == asp9_pkg::REG_DATA && wStrbQ[0] && !txBusy;

  // write response; unmapped offsets answer slave error
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bvalid <= 1'b0;
      bresp <= asp9_pkg::RESP_OKAY;
    end else if (wrDo) begin
      bvalid <= 1'b1;
      bresp <= (wrReg == asp9_pkg::REG_NONE) ? asp9_pkg::RESP_SLVERR
                                             : asp9_pkg::RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // control byte as software sees it; spare bit reads its reset value
  always_comb begin
    ctlVal = 8'h00;
    ctlVal[asp9_pkg::BIT_MODE] = frameNine;
    ctlVal[asp9_pkg::BIT_UNUSED] = asp9_pkg::CONTROL_RESET[asp9_pkg::BIT_UNUSED];
    ctlVal[asp9_pkg::BIT_MCE] = mceOn;
    ctlVal[asp9_pkg::BIT_REN] = renOn;
    ctlVal[asp9_pkg::BIT_TB8] = tb8;
    ctlVal[asp9_pkg::BIT_RB8] = rb8;
    ctlVal[asp9_pkg::BIT_TI] = txDoneFlag;
    ctlVal[asp9_pkg::BIT_RI] = rxDoneFlag;
  end

  // read mux; data offset returns the receive buffer only
  assign rdReg = decodeReg(araddr);
  always_comb begin
    rdVal = 32'h0000_0000;
    if (rdReg == asp9_pkg::REG_CONTROL) begin
      rdVal[7:0] = ctlVal;
    end else if (rdReg == asp9_pkg::REG_DATA) begin
      rdVal[7:0] = rxBuffer;
    end else if (rdReg == asp9_pkg::REG_BAUD) begin
      rdVal[7:0] = reloadByte;
      rdVal[10:8] = clkSel;
      rdVal[asp9_pkg::BIT_RUN] = timerRun;
      rdVal[asp9_pkg::BIT_IEN] = intEnable;
    end
  end

  // read channel, one outstanding read, answer one edge after address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= asp9_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdVal;
      rresp <= (rdReg == asp9_pkg::REG_NONE) ? asp9_pkg::RESP_SLVERR
                                             : asp9_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frameNine <= asp9_pkg::CONTROL_RESET[asp9_pkg::BIT_MODE];
      mceOn <= asp9_pkg::CONTROL_RESET[asp9_pkg::BIT_MCE];
      renOn <= asp9_pkg::CONTROL_RESET[asp9_pkg::BIT_REN];
      tb8 <= asp9_pkg::CONTROL_RESET[asp9_pkg::BIT_TB8];
    end else if (ctlWr) begin
      frameNine <= wDataQ[asp9_pkg::BIT_MODE];
      mceOn <= wDataQ[asp9_pkg::BIT_MCE];
      renOn <= wDataQ[asp9_pkg::BIT_REN];
      tb8 <= wDataQ[asp9_pkg::BIT_TB8];
    end
  end

  // flags clear only by software; a same-cycle set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txDoneFlag <= asp9_pkg::CONTROL_RESET[asp9_pkg::BIT_TI];
      rxDoneFlag <= asp9_pkg::CONTROL_RESET[asp9_pkg::BIT_RI];
    end else begin
      if (txDoneSet) txDoneFlag <= 1'b1;
      else if (ctlWr) txDoneFlag <= wDataQ[asp9_pkg::BIT_TI];
      if (rxAccept) rxDoneFlag <= 1'b1;
      else if (ctlWr) rxDoneFlag <= wDataQ[asp9_pkg::BIT_RI];
    end
  end

  // ninth-rx bit follows accepted frames, else software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rb8 <= asp9_pkg::CONTROL_RESET[asp9_pkg::BIT_RB8];
    end else if (rxAccept) begin
      rb8 <= rxNinthBit;
    end else if (ctlWr) begin
      rb8 <= wDataQ[asp9_pkg::BIT_RB8];
    end
  end

  // baud timer configuration, byte lanes zero and one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reloadByte <= 8'h00;
      clkSel <= asp9_pkg::CSEL_SYS;
      timerRun <= 1'b0;
      intEnable <= 1'b0;
    end else begin
      if (baudWr0) reloadByte <= wDataQ[7:0];
      if (baudWr1) begin
        clkSel <= wDataQ[10:8];
        timerRun <= wDataQ[asp9_pkg::BIT_RUN];
        intEnable <= wDataQ[asp9_pkg::BIT_IEN];
      end
    end
  end

  // request while enabled and a done flag stands
  always_ff @(posedge clk) begin
    if (sys_rst) irqReq <= 1'b0;
    else irqReq <= intEnable && (txDoneFlag || rxDoneFlag);
  end

  // receive pin filter; stage one feeds only stage two
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxSh <= 3'h7;
      rxLevel <= 1'b1;
    end else begin
      rxSh <= {rxSh[1:0], serialInPin};
      if (rxSh[1] == rxSh[2]) rxLevel <= rxSh[2];
    end
  end

  // falling line seen while idle and enabled
  assign rxStartEdge = (rxSh[1] == rxSh[2]) && !rxSh[2] && rxLevel;
  assign baudLink.rxRealign = rxState == asp9_pkg::RX_IDLE && renOn && rxStartEdge;

  // receive shifter kept apart from the buffer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState <= asp9_pkg::RX_IDLE;
      rxShift <= 8'h00;
      rxCnt <= 3'h0;
      rxDone <= 1'b0;
      rxCheckBit <= 1'b0;
      rxNinthBit <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      if (!renOn) begin
        rxState <= asp9_pkg::RX_IDLE;
      end else begin
        case (rxState)
          asp9_pkg::RX_IDLE: if (baudLink.rxRealign) begin
            rxState <= asp9_pkg::RX_START;
          end
          // start must still be low at midpoint
          asp9_pkg::RX_START: if (baudLink.rxBaud) begin
            rxCnt <= 3'h0;
            rxState <= rxLevel ? asp9_pkg::RX_IDLE : asp9_pkg::RX_DATA;
          end
          asp9_pkg::RX_DATA: if (baudLink.rxBaud) begin
            rxShift <= {rxLevel, rxShift[7:1]};
            rxCnt <= rxCnt + 3'h1;
            if (rxCnt == asp9_pkg::LAST_DATA_BIT)
              rxState <= frameNine ? asp9_pkg::RX_NINTH : asp9_pkg::RX_STOP;
          end
          asp9_pkg::RX_NINTH: if (baudLink.rxBaud) begin
            rxNinthBit <= rxLevel;
            rxState <= asp9_pkg::RX_STOP;
          end
          // stop kept in 8-bit, ignored in 9-bit
          default: if (baudLink.rxBaud) begin
            rxDone <= 1'b1;
            if (!frameNine) rxNinthBit <= rxLevel;
            rxCheckBit <= frameNine ? rxNinthBit : rxLevel;
            rxState <= asp9_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // accept if flag clear and filter passes
  assign rxAccept = rxDone && !rxDoneFlag && (!mceOn || rxCheckBit);

  // overrun keeps first byte, later frame dropped
  always_ff @(posedge clk) begin
    if (sys_rst) rxBuffer <= 8'h00;
    else if (rxAccept) rxBuffer <= rxShift;
  end

endmodule : asp9_top
`default_nettype wire

// >>> dv/asp9_remote.sv
// remote serial device model on the far side of the line
`timescale 1ns/100ps
`default_nettype none
module asp9_remote #(parameter int BIT_CLKS = 16) (
  input wire logic clk, // system clock
  input wire logic lineIn, // design transmit line
  input wire logic nineMode, // expect 9-bit frames
  output logic lineOut // design receive line
);
  logic [7:0] gotByte;
  logic gotNinth;
  int gotCount = 0;
  // line idles high between frames
  initial lineOut = 1'b1;
  // ninth bit one marks an address frame
  task automatic sendFrame(input logic [7:0] d, input logic nine, input logic b9);
    logic [10:0] bits;
    bits = nine ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      lineOut <= bits[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask : sendFrame
  // short low dip on the line, then idle long enough for a whole frame
  task automatic pulseLow(input int n);
    lineOut <= 1'b0;
    repeat (n) @(posedge clk);
    lineOut <= 1'b1;
    repeat (12 * BIT_CLKS) @(posedge clk);
  endtask : pulseLow
  // centre sampling, so a short bit shows as a wrong value
  always begin
    @(negedge lineIn);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      gotByte[i] = lineIn;
    end
    repeat (BIT_CLKS) @(posedge clk);
    gotNinth = lineIn;
    if (nineMode)
      repeat (BIT_CLKS) @(posedge clk);
    gotCount++;
  end
endmodule : asp9_remote
`default_nettype wire

// >>> dv/asp9_chk.sv
// bus and line checker for the serial port top
`timescale 1ns/100ps
`default_nettype none
module asp9_chk (
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic [asp9_pkg::ADDR_W-1:0] araddr, // ar address
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic serialOutPin, // tx line
  input wire logic irqReq // interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // answers, refusals and holding of the register bus
  chk_read_answer: assert property (
    arvalid && arready |=> rvalid && !arready) else $error("read not answered");
  chk_unmapped_err: assert property (
    arvalid && arready && araddr > 4'h8 |=> rresp == asp9_pkg::RESP_SLVERR
    && rdata == 32'h0000_0000) else $error("unmapped read accepted");
  chk_control_fixed: assert property (
    arvalid && arready && araddr == asp9_pkg::OFS_CONTROL |=> rdata[6] == 1'b1
    && rdata[31:8] == 24'h00_0000) else $error("control fixed bits wrong");
  chk_rdata_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  chk_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> !awready && !wready ##[0:1] bvalid)
    else $error("write not answered");
  // line and request level straight after reset
  chk_line_idle: assert property (
    $fell(sys_rst) |-> serialOutPin == 1'b1) else $error("line not idle high");
  chk_irq_quiet: assert property (
    $fell(sys_rst) |-> irqReq == 1'b0) else $error("request after reset");
  // a start bit spans at least the shortest bit period
  chk_start_min: assert property (
    $fell(serialOutPin) |-> !serialOutPin [*2]) else $error("start bit too short");
endmodule : asp9_chk
bind asp9_top asp9_chk asp9_chk_inst (.clk(clk), .sys_rst(sys_rst), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .serialOutPin(serialOutPin), .irqReq(irqReq));
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the 9-bit serial port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [3:0] CTL = asp9_pkg::OFS_CONTROL;
  localparam logic [3:0] DAT = asp9_pkg::OFS_DATA;
  localparam logic [3:0] BAU = asp9_pkg::OFS_BAUD;
  logic clk = 1'b0, sys_rst = 1'b1, nineMode = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, rxLine, serialOutPin, irqReq;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] b1, b2;
  int failures = 0, n_compared = 0, cyc = 0;
  logic [2:0] extPhase = 3'h0;
  asp9_top asp9_top_inst (.clk(clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serialInPin(rxLine), .serialOutPin(serialOutPin), .extOscClk(1'b0),
    .extTimerIn(extPhase[2]), .irqReq(irqReq));
  asp9_remote #(.BIT_CLKS(16)) asp9_remote_inst (.clk(clk), .lineIn(serialOutPin),
    .nineMode(nineMode), .lineOut(rxLine));
  // 50 ns clock
  initial forever #25 clk = ~clk;
  // external timer input, one rising edge every 8 cycles
  always @(posedge clk) extPhase <= extPhase + 3'h1;
  // hang guard, far above the few thousand cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // bit 6 of control always reads one
  function automatic logic [31:0] ctrlExp(input logic [7:0] v);
    return {24'h00_0000, v | 8'h40};
  endfunction : ctrlExp
  // write: each channel released at its own handshake
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        rs = bresp;
      end
    end while (bready);
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
      end
    end while (rready);
  endtask : rdr
  // send one byte and wait for the far side to see the frame
  task automatic tx(input logic [7:0] d);
    int c;
    c = asp9_remote_inst.gotCount;
    wr(DAT, {24'h00_0000, d});
    for (int i = 0; i < 800 && asp9_remote_inst.gotCount == c; i++) @(posedge clk);
  endtask : tx
  task automatic rx(input logic [7:0] d, input logic nine, input logic b9);
    asp9_remote_inst.sendFrame(d, nine, b9);
    repeat (4) @(posedge clk);
  endtask : rx
  initial begin
    void'($urandom(57000));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdr(CTL);
    check(rd, 32'h0000_0040);
    rdr(DAT);
    check(rd, 32'h0000_0000);
    rdr(4'hc);
    check(rs, asp9_pkg::RESP_SLVERR);
    // unmapped write answers an error and changes nothing
    wr(4'hc, 32'h0000_00ff);
    check(rs, asp9_pkg::RESP_SLVERR);
    rdr(CTL);
    check(rd, 32'h0000_0040);
    // every timer source, ending on the system clock at reload f8
    for (int s = 5; s >= 0; s--) begin
      wr(BAU, 32'h0000_18f8 | (32'(s) << 8));
      check(rs, asp9_pkg::RESP_OKAY);
      rdr(BAU);
      check(rd, 32'h0000_18f8 | (32'(s) << 8));
    end
    wr(CTL, 32'h0000_0010);
    b1 = 8'($urandom);
    tx(b1);
    check(asp9_remote_inst.gotByte, b1);
    rdr(CTL);
    check(rd, ctrlExp(8'h12));
    check(irqReq, 1'b1);
    wr(CTL, 32'h0000_0010);
    @(posedge clk);
    check(irqReq, 1'b0);
    // a dip shorter than half a bit must not start a frame
    asp9_remote_inst.pulseLow(4);
    rdr(CTL);
    check(rd, ctrlExp(8'h10));
    // second frame lands while the first is unread
    b1 = 8'($urandom);
    b2 = ~b1;
    rx(b1, 1'b0, 1'b0);
    rx(b2, 1'b0, 1'b0);
    rdr(DAT);
    check(rd, {24'h00_0000, b1});
    rdr(CTL);
    check(rd, ctrlExp(8'h15));
    wr(CTL, 32'h0000_00b0);
    rx(b2, 1'b1, 1'b0);
    rdr(CTL);
    check(rd, ctrlExp(8'hb0));
    rx(b2, 1'b1, 1'b1);
    rdr(DAT);
    check(rd, {24'h00_0000, b2});
    rdr(CTL);
    check(rd, ctrlExp(8'hb5));
    wr(CTL, 32'h0000_0080);
    rx(b1, 1'b1, 1'b1);
    rdr(CTL);
    check(rd, ctrlExp(8'h80));
    nineMode <= 1'b1;
    wr(CTL, 32'h0000_0088);
    tx(b1);
    check(asp9_remote_inst.gotByte, b1);
    check(asp9_remote_inst.gotNinth, 1'b1);
    // external input clocks the timer: reload ff gives 16 cycles a bit
    repeat (20) @(posedge clk);
    wr(BAU, 32'h0000_1dff);
    b2 = 8'($urandom);
    tx(b2);
    check(asp9_remote_inst.gotByte, b2);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
